// File: sbc_pkg.sv
// Purpose: Shared constants and types of the standby and oscillation stabilization controller.
// Assumes: One clock, sys_clk, with crystal cycles delivered as single-cycle tick pulses.
// Notes: The rules that the two ends keep are listed below.
package sbc_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int SEL_W = 3;
  localparam int STAT_W = 5;
  localparam logic [15:0] ADDR_STATUS = 16'hffa3;
  localparam logic [15:0] ADDR_SELECT = 16'hffa4;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [2:0] SELECT_RST = 3'h5;
  // Crystal cycle exponents of the five stabilization steps, shortest first.
  localparam int EXP_A = 11;
  localparam int EXP_B = 13;
  localparam int EXP_C = 14;
  localparam int EXP_D = 15;
  localparam int EXP_E = 16;
  localparam logic [2:0] SEL_A = 3'h1;
  localparam logic [2:0] SEL_B = 3'h2;
  localparam logic [2:0] SEL_C = 3'h3;
  localparam logic [2:0] SEL_D = 3'h4;
  localparam logic [2:0] SEL_E = 3'h5;
  // Host register indices and command bits.
  localparam logic [2:0] H_CMD = 3'h0;
  localparam logic [2:0] H_DADDR = 3'h1;
  localparam logic [2:0] H_DWDATA = 3'h2;
  localparam logic [2:0] H_DRDATA = 3'h3;
  localparam logic [2:0] H_STAT = 3'h4;
  localparam int CMD_HALT = 0;
  localparam int CMD_STOP = 1;
  localparam int CMD_DWR = 2;
  localparam int CMD_DRD = 3;
  localparam int CMD_BIT = 4;
  localparam int CMD_RESUME = 5;
  typedef enum logic [1:0] {
    SBC_RUN = 2'b00,
    SBC_HALT = 2'b01,
    SBC_STOP = 2'b10,
    SBC_WAIT = 2'b11
  } sbc_mode_t;
endpackage

// File: sbc_if.sv
// Purpose: Link between the CPU core end and the standby controller end.
// Assumes: All signals synchronous to sys_clk.
// Notes: Strobes are single-cycle pulses; read data follows a read by one cycle.
`timescale 1ns/10ps
`default_nettype none
interface sbc_if;
  logic halt_exec;
  logic stop_exec;
  logic irq_req;
  logic [15:0] bus_addr;
  logic [7:0] bus_wdata;
  logic bus_wr;
  logic bus_rd;
  logic bus_bit;
  logic [7:0] bus_rdata;
  logic cpu_run;
  sbc_pkg::sbc_mode_t mode;
  modport dev (
    input halt_exec, stop_exec, irq_req, bus_addr, bus_wdata, bus_wr, bus_rd, bus_bit,
    output bus_rdata, cpu_run, mode
  );
  modport cpu (
    output halt_exec, stop_exec, irq_req, bus_addr, bus_wdata, bus_wr, bus_rd, bus_bit,
    input bus_rdata, cpu_run, mode
  );
endinterface
`default_nettype wire

// File: sbc_stab_counter.sv
// Purpose: Crystal oscillation stabilization counter with thermometer status.
// Assumes: tick is high for one sys_clk cycle per counted crystal cycle.
// Notes: The count freezes at the selected limit, so later steps never show.
`timescale 1ns/10ps
`default_nettype none
module sbc_stab_counter #(
  parameter int EXP_A = sbc_pkg::EXP_A,
  parameter int EXP_B = sbc_pkg::EXP_B,
  parameter int EXP_C = sbc_pkg::EXP_C,
  parameter int EXP_D = sbc_pkg::EXP_D,
  parameter int EXP_E = sbc_pkg::EXP_E
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Control
  input wire logic clear,
  input wire logic tick,
  input wire logic [2:0] sel,
  // Status
  output logic [4:0] status,
  output logic done
);
  localparam int CW = EXP_E + 1;
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic [4:0] status;
    logic done;
  } sbc_cnt_st_t;
  sbc_cnt_st_t st_r;
  sbc_cnt_st_t st_nxt;

  function automatic logic [CW-1:0] step_count(input int e);
    step_count = CW'(1) << e;
  endfunction

  // Prohibited codes fall back to the longest wait.
  function automatic logic [CW-1:0] limit_of(input logic [2:0] code);
    unique case (code)
      sbc_pkg::SEL_A: limit_of = step_count(EXP_A);
      sbc_pkg::SEL_B: limit_of = step_count(EXP_B);
      sbc_pkg::SEL_C: limit_of = step_count(EXP_C);
      sbc_pkg::SEL_D: limit_of = step_count(EXP_D);
      default: limit_of = step_count(EXP_E);
    endcase
  endfunction

  always_comb begin
    st_nxt = st_r;
    if (clear) begin
      st_nxt.cnt = '0;
      st_nxt.status = '0;
      st_nxt.done = 1'b0;
    end else begin
      if (tick && st_r.cnt < limit_of(sel)) begin
        st_nxt.cnt = st_r.cnt + CW'(1);
      end
      // Bit 4 is the shortest step; bits are only ever set here.
      st_nxt.status[4] = st_r.status[4] | (st_nxt.cnt >= step_count(EXP_A));
      st_nxt.status[3] = st_r.status[3] | (st_nxt.cnt >= step_count(EXP_B));
      st_nxt.status[2] = st_r.status[2] | (st_nxt.cnt >= step_count(EXP_C));
      st_nxt.status[1] = st_r.status[1] | (st_nxt.cnt >= step_count(EXP_D));
      st_nxt.status[0] = st_r.status[0] | (st_nxt.cnt >= step_count(EXP_E));
      st_nxt.done = st_nxt.cnt >= limit_of(sel);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign status = st_r.status;
  assign done = st_r.done;
endmodule
`default_nettype wire

// File: sbc_device.sv
// Purpose: Standby controller end: halt and stop modes, wake-up and stabilization wait.
// Assumes: Crystal cycles arrive as one-cycle ticks; the clock generator asks for oscillators.
// Notes: Standby keeps the stored state untouched; only clock enables, the hold level and the stabilization count and status move.
`timescale 1ns/10ps
`default_nettype none
module sbc_device #(
  parameter int EXP_A = sbc_pkg::EXP_A,
  parameter int EXP_B = sbc_pkg::EXP_B,
  parameter int EXP_C = sbc_pkg::EXP_C,
  parameter int EXP_D = sbc_pkg::EXP_D,
  parameter int EXP_E = sbc_pkg::EXP_E
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // CPU core link
  sbc_if.dev lnk,
  // Clock generator requests
  input wire logic xtal_req,
  input wire logic ihs_req,
  input wire logic cpu_on_xtal,
  input wire logic main_osc_stop_wr,
  // Crystal oscillator feedback
  input wire logic xtal_stable,
  input wire logic xtal_tick,
  // Clock and retention controls
  output logic osc_xtal_en,
  output logic osc_ihs_en,
  output logic cpu_clk_en,
  output logic retain_hold
);
  typedef struct packed {
    sbc_pkg::sbc_mode_t mode;
    logic [2:0] sel;
    logic [7:0] rdata;
    logic cpu_run;
    logic xtal_en;
    logic ihs_en;
    logic hold;
  } sbc_dev_st_t;
  sbc_dev_st_t st_r;
  sbc_dev_st_t st_nxt;

  logic cnt_clear;
  logic cnt_tick;
  logic cnt_done;
  logic [4:0] cnt_status;
  logic stop_take;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] reg_addr);
    hit = (a == reg_addr);
  endfunction

  assign stop_take = lnk.stop_exec && st_r.mode == sbc_pkg::SBC_RUN;
  // Main-oscillator stop written to 1 restarts the status as well.
  assign cnt_clear = stop_take || main_osc_stop_wr;
  // Start-up time before real oscillation never counts.
  assign cnt_tick = xtal_tick && xtal_stable && st_r.xtal_en;

  sbc_stab_counter #(
    .EXP_A(EXP_A),
    .EXP_B(EXP_B),
    .EXP_C(EXP_C),
    .EXP_D(EXP_D),
    .EXP_E(EXP_E)
  ) u_cnt (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .clear(cnt_clear),
    .tick(cnt_tick),
    .sel(st_r.sel),
    .status(cnt_status),
    .done(cnt_done)
  );

  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata = 8'h00;
    unique case (st_r.mode)
      sbc_pkg::SBC_RUN: begin
        if (stop_take) begin
          st_nxt.mode = sbc_pkg::SBC_STOP;
        end else if (lnk.halt_exec) begin
          st_nxt.mode = sbc_pkg::SBC_HALT;
        end
      end
      sbc_pkg::SBC_HALT: begin
        if (lnk.irq_req) begin
          st_nxt.mode = sbc_pkg::SBC_RUN;
        end
      end
      sbc_pkg::SBC_STOP: begin
        // A crystal-clocked CPU must wait out the selected time first.
        if (lnk.irq_req) begin
          st_nxt.mode = cpu_on_xtal ? sbc_pkg::SBC_WAIT : sbc_pkg::SBC_RUN;
        end
      end
      sbc_pkg::SBC_WAIT: begin
        if (cnt_done) begin
          st_nxt.mode = sbc_pkg::SBC_RUN;
        end
      end
    endcase
    st_nxt.cpu_run = st_nxt.mode == sbc_pkg::SBC_RUN;
    // Halt leaves every oscillator as it was; stop kills the two fast ones.
    st_nxt.xtal_en = xtal_req && st_nxt.mode != sbc_pkg::SBC_STOP;
    st_nxt.ihs_en = ihs_req && st_nxt.mode != sbc_pkg::SBC_STOP;
    st_nxt.hold = st_nxt.mode != sbc_pkg::SBC_RUN;
    // A bit access may not alter the select register.
    if (lnk.bus_wr && !lnk.bus_bit && hit(lnk.bus_addr, sbc_pkg::ADDR_SELECT)) begin
      st_nxt.sel = lnk.bus_wdata[2:0];
    end
    if (lnk.bus_rd) begin
      if (hit(lnk.bus_addr, sbc_pkg::ADDR_STATUS)) begin
        st_nxt.rdata = {3'h0, cnt_status};
      end else if (hit(lnk.bus_addr, sbc_pkg::ADDR_SELECT)) begin
        st_nxt.rdata = {5'h00, st_r.sel};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st_r.mode <= sbc_pkg::SBC_RUN;
      st_r.sel <= sbc_pkg::SELECT_RST;
      st_r.rdata <= sbc_pkg::STATUS_RST;
      st_r.cpu_run <= 1'b1;
      st_r.xtal_en <= 1'b0;
      st_r.ihs_en <= 1'b1;
      st_r.hold <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign lnk.bus_rdata = st_r.rdata;
  assign lnk.cpu_run = st_r.cpu_run;
  assign lnk.mode = st_r.mode;
  assign osc_xtal_en = st_r.xtal_en;
  assign osc_ihs_en = st_r.ihs_en;
  assign cpu_clk_en = st_r.cpu_run;
  assign retain_hold = st_r.hold;
endmodule
`default_nettype wire

// File: sbc_host.sv
// Purpose: CPU core end: turns software orders into standby instructions and link accesses.
// Assumes: Software port reads answer one cycle after the read strobe.
// Notes: Link reads land in a mirror register that software fetches afterwards.
`timescale 1ns/10ps
`default_nettype none
module sbc_host (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Software port
  input wire logic [2:0] sw_addr,
  input wire logic [15:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [15:0] sw_rdata,
  // Interrupt controller
  input wire logic irq_in,
  // Peripheral control
  output logic periph_quiesce,
  // Standby controller link
  sbc_if.cpu lnk
);
  typedef struct packed {
    logic halt;
    logic stop;
    logic stop_pend;
    logic irq;
    logic [15:0] daddr;
    logic [7:0] dwdata;
    logic wr;
    logic rd;
    logic bitacc;
    logic rd_wait;
    logic [7:0] drdata;
    logic [15:0] rdata;
    logic quiesce;
  } sbc_host_st_t;
  sbc_host_st_t st_r;
  sbc_host_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.halt = 1'b0;
    st_nxt.stop = 1'b0;
    st_nxt.wr = 1'b0;
    st_nxt.rd = 1'b0;
    st_nxt.rdata = 16'h0000;
    st_nxt.irq = irq_in;
    st_nxt.rd_wait = st_r.rd;
    if (st_r.rd_wait) begin
      st_nxt.drdata = lnk.bus_rdata;
    end
    // Peripherals are quiesced one cycle ahead of the stop instruction.
    if (st_r.stop_pend) begin
      st_nxt.stop = 1'b1;
      st_nxt.stop_pend = 1'b0;
    end
    if (sw_wr) begin
      unique case (sw_addr)
        sbc_pkg::H_CMD: begin
          st_nxt.halt = sw_wdata[sbc_pkg::CMD_HALT] && !sw_wdata[sbc_pkg::CMD_STOP];
          if (sw_wdata[sbc_pkg::CMD_STOP]) begin
            st_nxt.quiesce = 1'b1;
            st_nxt.stop_pend = 1'b1;
          end else if (sw_wdata[sbc_pkg::CMD_RESUME]) begin
            st_nxt.quiesce = 1'b0;
          end
          // Select writes are held back while a stabilization wait runs.
          st_nxt.wr = sw_wdata[sbc_pkg::CMD_DWR] && !(lnk.mode == sbc_pkg::SBC_WAIT
            && st_r.daddr == sbc_pkg::ADDR_SELECT);
          st_nxt.rd = sw_wdata[sbc_pkg::CMD_DRD] && !sw_wdata[sbc_pkg::CMD_DWR];
          st_nxt.bitacc = sw_wdata[sbc_pkg::CMD_BIT];
        end
        sbc_pkg::H_DADDR: st_nxt.daddr = sw_wdata;
        sbc_pkg::H_DWDATA: st_nxt.dwdata = sw_wdata[7:0];
        default: begin
        end
      endcase
    end
    if (sw_rd) begin
      unique case (sw_addr)
        sbc_pkg::H_DADDR: st_nxt.rdata = st_r.daddr;
        sbc_pkg::H_DWDATA: st_nxt.rdata = {8'h00, st_r.dwdata};
        sbc_pkg::H_DRDATA: st_nxt.rdata = {8'h00, st_r.drdata};
        sbc_pkg::H_STAT: st_nxt.rdata = {10'h000, st_r.rd_wait | st_r.rd, st_r.stop_pend,
          st_r.quiesce, lnk.cpu_run, lnk.mode};
        default: st_nxt.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sw_rdata = st_r.rdata;
  assign periph_quiesce = st_r.quiesce;
  assign lnk.halt_exec = st_r.halt;
  assign lnk.stop_exec = st_r.stop;
  assign lnk.irq_req = st_r.irq;
  assign lnk.bus_addr = st_r.daddr;
  assign lnk.bus_wdata = st_r.dwdata;
  assign lnk.bus_wr = st_r.wr;
  assign lnk.bus_rd = st_r.rd;
  assign lnk.bus_bit = st_r.bitacc;
endmodule
`default_nettype wire

// File: sbc_properties.sv
// Purpose: Link properties of the standby controller pair.
// Assumes: One clock; resetn synchronous and active low.
// Notes: Sees only the signals carried between the two ends.
`timescale 1ns/10ps
`default_nettype none
module sbc_properties (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Standby requests
  input wire logic halt_exec,
  input wire logic stop_exec,
  input wire logic irq_req,
  // Register access
  input wire logic [15:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic bus_bit,
  input wire logic [7:0] bus_rdata,
  // Status
  input wire logic cpu_run,
  input wire sbc_pkg::sbc_mode_t mode
);
  // Longest simulated wait is 128 ticks at one tick per two clocks, plus slack.
  localparam int WAIT_MAX = 600;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  chk_halt_entry: assert property (
    mode == sbc_pkg::SBC_RUN && halt_exec && !stop_exec |=> mode == sbc_pkg::SBC_HALT && !cpu_run)
    else $error("halt not entered");
  chk_stop_entry: assert property (
    mode == sbc_pkg::SBC_RUN && stop_exec |=> mode == sbc_pkg::SBC_STOP && !cpu_run)
    else $error("stop not entered");
  chk_halt_wake: assert property (
    mode == sbc_pkg::SBC_HALT && irq_req |=> mode == sbc_pkg::SBC_RUN && cpu_run)
    else $error("halt not left at once");
  chk_stop_wake: assert property (
    mode == sbc_pkg::SBC_STOP && irq_req |=> mode == sbc_pkg::SBC_WAIT || mode == sbc_pkg::SBC_RUN)
    else $error("stop not left");
  chk_standby_stays: assert property (
    (mode == sbc_pkg::SBC_HALT || mode == sbc_pkg::SBC_STOP) && !irq_req |=> $stable(mode))
    else $error("standby left without request");
  chk_wait_bounded: assert property (
    $rose(mode == sbc_pkg::SBC_WAIT) |-> ##[1:WAIT_MAX] mode == sbc_pkg::SBC_RUN)
    else $error("stabilization wait never ends");
  chk_cpu_held: assert property (
    cpu_run == (mode == sbc_pkg::SBC_RUN))
    else $error("cpu clock state disagrees with mode");
  chk_status_upper: assert property (
    bus_rd && bus_addr == sbc_pkg::ADDR_STATUS |=> bus_rdata[7:5] == 3'h0)
    else $error("status upper bits not zero");
  chk_select_upper: assert property (
    bus_rd && bus_addr == sbc_pkg::ADDR_SELECT |=> bus_rdata[7:3] == 5'h00)
    else $error("select upper bits not zero");
  cov_halt: cover property (mode == sbc_pkg::SBC_HALT && irq_req);
  cov_wait: cover property ($rose(mode == sbc_pkg::SBC_WAIT));
  cov_status: cover property (bus_rd && bus_addr == sbc_pkg::ADDR_STATUS);
endmodule
`default_nettype wire

// File: sbc_tb.sv
// Purpose: Self-checking bench of the host and device ends joined by their link.
// Assumes: Exponents 3 to 7 stand in for the long crystal counts.
// Notes: A tick comes every second clock, so n ticks last 2n cycles.
`timescale 1ns/10ps
`default_nettype none
module standby_osc_stabilization_ctrl_tb;
  logic sys_clk;
  logic resetn;
  logic [2:0] sw_addr;
  logic [15:0] sw_wdata;
  logic sw_wr;
  logic sw_rd;
  logic [15:0] sw_rdata;
  logic irq_in;
  logic periph_quiesce;
  logic xtal_req;
  logic ihs_req;
  logic cpu_on_xtal;
  logic main_osc_stop_wr;
  logic xtal_stable;
  logic xtal_tick = 1'b0;
  logic osc_xtal_en;
  logic osc_ihs_en;
  logic cpu_clk_en;
  logic retain_hold;
  logic [15:0] rd;
  int bad_count;
  int comparisons;
  int n;
  sbc_if lnk ();
  sbc_host sbc_host_i (.sys_clk(sys_clk), .resetn(resetn), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .irq_in(irq_in),
    .periph_quiesce(periph_quiesce), .lnk(lnk));
  sbc_device #(.EXP_A(3), .EXP_B(4), .EXP_C(5), .EXP_D(6), .EXP_E(7)) sbc_device_i (
    .sys_clk(sys_clk), .resetn(resetn), .lnk(lnk), .xtal_req(xtal_req), .ihs_req(ihs_req),
    .cpu_on_xtal(cpu_on_xtal), .main_osc_stop_wr(main_osc_stop_wr),
    .xtal_stable(xtal_stable), .xtal_tick(xtal_tick), .osc_xtal_en(osc_xtal_en),
    .osc_ihs_en(osc_ihs_en), .cpu_clk_en(cpu_clk_en), .retain_hold(retain_hold));
  sbc_properties sbc_properties_i (.sys_clk(sys_clk), .resetn(resetn),
    .halt_exec(lnk.halt_exec), .stop_exec(lnk.stop_exec), .irq_req(lnk.irq_req),
    .bus_addr(lnk.bus_addr), .bus_wdata(lnk.bus_wdata), .bus_wr(lnk.bus_wr),
    .bus_rd(lnk.bus_rd), .bus_bit(lnk.bus_bit), .bus_rdata(lnk.bus_rdata),
    .cpu_run(lnk.cpu_run), .mode(lnk.mode));
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    xtal_tick <= ~xtal_tick;
  end
  task automatic test_done();
    if (bad_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic sw_write(input logic [2:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge sys_clk);
    sw_wr <= 1'b0;
  endtask
  task automatic sw_read(input logic [2:0] a, output logic [15:0] d);
    @(posedge sys_clk);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge sys_clk);
    sw_rd <= 1'b0;
    @(negedge sys_clk);
    d = sw_rdata;
  endtask
  task automatic dev_read(input logic [15:0] a, output logic [15:0] d);
    sw_write(sbc_pkg::H_DADDR, a);
    sw_write(sbc_pkg::H_CMD, 16'h0008);
    repeat (3) @(posedge sys_clk);
    sw_read(sbc_pkg::H_DRDATA, d);
  endtask
  task automatic dev_write(input logic [15:0] a, input logic [15:0] v, input logic [15:0] c);
    sw_write(sbc_pkg::H_DADDR, a);
    sw_write(sbc_pkg::H_DWDATA, v);
    sw_write(sbc_pkg::H_CMD, c);
  endtask
  task automatic wait_mode(input sbc_pkg::sbc_mode_t m, input int lim, output int cyc);
    cyc = 0;
    while (lnk.mode !== m && cyc < lim) begin
      @(negedge sys_clk);
      cyc++;
    end
    if (lnk.mode !== m) begin
      check("mode", 16'(m), 16'(lnk.mode));
      test_done();
    end
  endtask
  initial begin
    resetn = 1'b0;
    sw_addr = 3'h0;
    sw_wdata = 16'h0000;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    irq_in = 1'b0;
    xtal_req = 1'b0;
    ihs_req = 1'b1;
    cpu_on_xtal = 1'b1;
    main_osc_stop_wr = 1'b0;
    xtal_stable = 1'b0;
    bad_count = 0;
    comparisons = 0;
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    dev_read(sbc_pkg::ADDR_STATUS, rd);
    check("status reset", 16'h0000, rd);
    dev_read(sbc_pkg::ADDR_SELECT, rd);
    check("select reset", 16'h0005, rd);
    dev_read(16'h0000, rd);
    check("unmapped", 16'h0000, rd);
    dev_write(sbc_pkg::ADDR_STATUS, 16'h00ff, 16'h0004);
    dev_read(sbc_pkg::ADDR_STATUS, rd);
    check("status write", 16'h0000, rd);
    dev_write(sbc_pkg::ADDR_SELECT, 16'h0002, 16'h0014);
    dev_read(sbc_pkg::ADDR_SELECT, rd);
    check("select bit write", 16'h0005, rd);
    xtal_req <= 1'b1;
    sw_write(sbc_pkg::H_CMD, 16'h0001);
    wait_mode(sbc_pkg::SBC_HALT, 6, n);
    check("halt cpu clk", 16'h0000, {15'h0, cpu_clk_en});
    check("halt hold", 16'h0001, {15'h0, retain_hold});
    check("halt osc", 16'h0003, {14'h0, osc_xtal_en, osc_ihs_en});
    sw_read(sbc_pkg::H_STAT, rd);
    check("host stat halt", 16'h0001, rd);
    irq_in <= 1'b1;
    wait_mode(sbc_pkg::SBC_RUN, 3, n);
    irq_in <= 1'b0;
    dev_read(sbc_pkg::ADDR_SELECT, rd);
    check("select kept", 16'h0005, rd);
    // Every legal select code; the first pass also holds the crystal unstable.
    for (int c = 1; c <= 5; c++) begin
      xtal_stable <= (c != 1);
      dev_write(sbc_pkg::ADDR_SELECT, 16'(c), 16'h0004);
      sw_write(sbc_pkg::H_CMD, 16'h0002);
      wait_mode(sbc_pkg::SBC_STOP, 8, n);
      check("quiesce", 16'h0001, {15'h0, periph_quiesce});
      check("stop osc", 16'h0000, {14'h0, osc_xtal_en, osc_ihs_en});
      irq_in <= 1'b1;
      wait_mode(sbc_pkg::SBC_WAIT, 4, n);
      irq_in <= 1'b0;
      if (c == 1) begin
        repeat (40) @(negedge sys_clk);
        check("unstable wait", 16'(sbc_pkg::SBC_WAIT), 16'(lnk.mode));
        xtal_stable <= 1'b1;
      end
      wait_mode(sbc_pkg::SBC_RUN, 300, n);
      check("wait length", 16'h0001, 16'(n >= (2 << (c + 2))));
      dev_read(sbc_pkg::ADDR_STATUS, rd);
      check("status", {11'h000, 5'h1f & ~(5'h1f >> c)}, rd);
      sw_write(sbc_pkg::H_CMD, 16'h0020);
      @(negedge sys_clk);
      check("resume", 16'h0000, {15'h0, periph_quiesce});
    end
    cpu_on_xtal <= 1'b0;
    sw_write(sbc_pkg::H_CMD, 16'h0002);
    wait_mode(sbc_pkg::SBC_STOP, 8, n);
    irq_in <= 1'b1;
    wait_mode(sbc_pkg::SBC_RUN, 4, n);
    irq_in <= 1'b0;
    n = 0;
    rd = 16'h0000;
    while (rd !== 16'h001f && n < 60) begin
      dev_read(sbc_pkg::ADDR_STATUS, rd);
      n++;
    end
    check("status poll", 16'h001f, rd);
    xtal_stable <= 1'b0;
    @(posedge sys_clk);
    main_osc_stop_wr <= 1'b1;
    @(posedge sys_clk);
    main_osc_stop_wr <= 1'b0;
    dev_read(sbc_pkg::ADDR_STATUS, rd);
    check("status osc stop", 16'h0000, rd);
    test_done();
  end
endmodule
`default_nettype wire
